/* File: compare_channel.sv */
// Purpose: one 16-bit output compare channel with match detection
// Assumes: count comes from the counter and tick from the prescaler, on the same clock
// Notes: match is a registered one-cycle pulse, one cycle after equality
`timescale 1ns/1ps
module compare_channel
  import timer4_pkg::*;
#(
  parameter logic [BYTE_W-1:0] LOW_WMASK = LOW_WMASK_A
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // whole-word write from the staging latch
  input wire logic commit,
  input wire logic [BYTE_W-1:0] highByte,
  input wire logic [BYTE_W-1:0] lowByte,
  // counter side
  input wire logic tick,
  input wire logic block,
  input wire logic [VALUE_W-1:0] liveCount,
  // results
  output logic [VALUE_W-1:0] compareValue,
  output logic matchPulse
);

  // ************************************************************
  // channel state
  // ************************************************************
  typedef struct packed {
    logic [VALUE_W-1:0] value;
    logic match;
  } channel_state_t;

  channel_state_t state_q;
  channel_state_t state_d;

  // both bytes land in one edge so the value is never half old
  always_comb begin
    state_d = state_q;
    if (commit) begin
      state_d.value = {highByte, (lowByte & LOW_WMASK) |
                       (state_q.value[BYTE_W-1:0] & ~LOW_WMASK)};
    end
    // compared on every tick, dropped while a counter write blocks it
    state_d.match = tick && !block && (liveCount == state_q.value);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q.value <= VALUE_RESET;
      state_q.match <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign compareValue = state_q.value;
  assign matchPulse = state_q.match;

endmodule : compare_channel

/* File: cpu_bus_model.sv */
// Purpose: cpu side of the register bus, wishbone single cycles
// Assumes: ack comes from the slave on a rising edge
// Notes: a wait past its bound returns ok low
`timescale 1ns/1ps
module cpu_bus_model
  import timer4_pkg::*;
(
  // clock
  input wire logic clock,
  // bus
  output wb_req_t wbReq,
  input wire wb_rsp_t wbRsp
);
  // idle bus from time zero
  initial wbReq = '0;

  // request held until ack is seen on an edge, then released
  task automatic access(input logic we, input logic [IDX_W-1:0] idx,
      input logic [BYTE_W-1:0] wd, output logic [BYTE_W-1:0] rd, output logic ok);
    ok = 1'b0;
    rd = BYTE_RESET;
    @(posedge clock);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1,
      dat: {24'h000000, wd}};
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clock);
      if (wbRsp.ack === 1'b1) begin
        ok = 1'b1;
        rd = wbRsp.dat[BYTE_W-1:0];
      end
    end
    wbReq <= '0;
  endtask : access

  // high byte only fills the latch, so it must go first
  task automatic write16(input logic [IDX_W-1:0] lowIdx, input logic [VALUE_W-1:0] v,
      output logic ok);
    logic [BYTE_W-1:0] rd;
    logic okHigh;
    access(1'b1, lowIdx + 8'h01, v[15:8], rd, okHigh);
    access(1'b1, lowIdx, v[7:0], rd, ok);
    ok = ok & okHigh;
  endtask : write16
endmodule : cpu_bus_model

/* File: live_counter.sv */
// Purpose: 16-bit up counter with a whole-word load port
// Assumes: tick is a one-cycle pulse from the prescaler on the same clock
// Notes: a load in the same cycle as a tick wins over the increment
`timescale 1ns/1ps
module live_counter
  import timer4_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // control
  input wire logic tick,
  input wire logic load,
  input wire logic [VALUE_W-1:0] loadValue,
  // state
  output logic [VALUE_W-1:0] liveCount
);

  // ************************************************************
  // counter state
  // ************************************************************
  typedef struct packed {
    logic [VALUE_W-1:0] count;
  } counter_state_t;

  counter_state_t state_q;
  counter_state_t state_d;

  // next count: software load beats the running increment
  always_comb begin
    state_d = state_q;
    if (load) begin
      state_d.count = loadValue;
    end else if (tick) begin
      state_d.count = state_q.count + COUNT_STEP;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q.count <= VALUE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign liveCount = state_q.count;

endmodule : live_counter

/* File: timer4_counter_compare_regs.sv */
// Purpose: register side of a 16-bit timer: live count and three compare channels
// Assumes: classic wishbone master, tick pulse from a prescaler on the same clock
// Notes: one shared high-byte staging latch serves every 16-bit register
`timescale 1ns/1ps
module timer4_counter_compare_regs
  import timer4_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // wishbone slave
  input wire wb_req_t wbReq,
  output wb_rsp_t wbRsp,
  // timer clock tick from the prescaler
  input wire logic timerTick,
  // compare match requests towards the interrupt flag logic
  output logic [CHANNELS-1:0] compareMatch,
  // live values for the rest of the timer
  output logic [VALUE_W-1:0] liveCount
);

  // ************************************************************
  // state and bus decode
  // ************************************************************
  top_state_t state_q;
  top_state_t state_d;

  logic access;
  logic wrByte;
  logic [IDX_W-1:0] index;
  logic [BYTE_W-1:0] wrData;
  logic countWrite;
  logic [CHANNELS-1:0] cmpCommit;
  logic compareBlock;
  logic [VALUE_W-1:0] compareAValue;
  logic [VALUE_W-1:0] compareBValue;
  logic [VALUE_W-1:0] compareCValue;
  logic [CHANNELS-1:0] matchPulse;

  // a new request is taken only while no ack is outstanding
  assign access = wbReq.cyc && wbReq.stb && (state_q.bus == BUS_IDLE);
  // byte lane 0 carries every register; other lanes alone write nothing
  assign wrByte = access && wbReq.we && wbReq.sel[0];
  assign index = wbReq.adr[IDX_LSB +: IDX_W];
  assign wrData = wbReq.dat[BYTE_W-1:0];

  // low-byte writes commit the latch plus the bus byte as one word
  assign countWrite = wrByte && (index == IDX_COUNT_LOW);
  assign cmpCommit[CH_A] = wrByte && (index == IDX_CMP_A_LOW);
  assign cmpCommit[CH_B] = wrByte && (index == IDX_CMP_B_LOW);
  assign cmpCommit[CH_C] = wrByte && (index == IDX_CMP_C_LOW);

  // a count write landing on a tick edge also blocks that tick's compare
  assign compareBlock = state_q.blockPending || countWrite;

  // ************************************************************
  // counter and compare channels
  // ************************************************************
  // counter load uses the shared latch as its high byte
  live_counter u_counter (
    .clock(clock),
    .srst(srst),
    .tick(timerTick),
    .load(countWrite),
    .loadValue({state_q.temp, wrData}),
    .liveCount(liveCount)
  );

  // channel a: all bits writable
  compare_channel #(
    .LOW_WMASK(LOW_WMASK_A)
  ) u_cmp_a (
    .clock(clock),
    .srst(srst),
    .commit(cmpCommit[CH_A]),
    .highByte(state_q.temp),
    .lowByte(wrData),
    .tick(timerTick),
    .block(compareBlock),
    .liveCount(liveCount),
    .compareValue(compareAValue),
    .matchPulse(matchPulse[CH_A])
  );

  // channel b: low byte bit 7 read-only
  compare_channel #(
    .LOW_WMASK(LOW_WMASK_BC)
  ) u_cmp_b (
    .clock(clock),
    .srst(srst),
    .commit(cmpCommit[CH_B]),
    .highByte(state_q.temp),
    .lowByte(wrData),
    .tick(timerTick),
    .block(compareBlock),
    .liveCount(liveCount),
    .compareValue(compareBValue),
    .matchPulse(matchPulse[CH_B])
  );

  // channel c: low byte bit 7 read-only
  compare_channel #(
    .LOW_WMASK(LOW_WMASK_BC)
  ) u_cmp_c (
    .clock(clock),
    .srst(srst),
    .commit(cmpCommit[CH_C]),
    .highByte(state_q.temp),
    .lowByte(wrData),
    .tick(timerTick),
    .block(compareBlock),
    .liveCount(liveCount),
    .compareValue(compareCValue),
    .matchPulse(matchPulse[CH_C])
  );

  // ************************************************************
  // next state: bus, staging latch, block, status
  // ************************************************************
  always_comb begin
    state_d = state_q;

    // ack lasts exactly one cycle, then the slave is idle again
    case (state_q.bus)
      BUS_IDLE: begin
        if (access) begin
          state_d.bus = BUS_ACK;
        end
      end
      BUS_ACK: begin
        state_d.bus = BUS_IDLE;
      end
      default: begin
        state_d.bus = BUS_IDLE;
      end
    endcase

    // read data, captured with the request so it stands with ack
    if (access) begin
      state_d.rdata = DATA_ZERO;
      if (!wbReq.we) begin
        case (index)
          IDX_COUNT_LOW: begin
            state_d.rdata[BYTE_W-1:0] = liveCount[BYTE_W-1:0];
            // freeze the high half so a later high read pairs up
            state_d.temp = liveCount[VALUE_W-1:BYTE_W];
          end
          IDX_COUNT_HIGH: begin
            state_d.rdata[BYTE_W-1:0] = state_q.temp;
          end
          IDX_CMP_A_LOW: begin
            state_d.rdata[BYTE_W-1:0] = compareAValue[BYTE_W-1:0];
          end
          IDX_CMP_A_HIGH: begin
            state_d.rdata[BYTE_W-1:0] = compareAValue[VALUE_W-1:BYTE_W];
          end
          IDX_CMP_B_LOW: begin
            state_d.rdata[BYTE_W-1:0] = compareBValue[BYTE_W-1:0];
          end
          IDX_CMP_B_HIGH: begin
            state_d.rdata[BYTE_W-1:0] = compareBValue[VALUE_W-1:BYTE_W];
          end
          IDX_CMP_C_LOW: begin
            state_d.rdata[BYTE_W-1:0] = compareCValue[BYTE_W-1:0];
          end
          IDX_CMP_C_HIGH: begin
            state_d.rdata[BYTE_W-1:0] = compareCValue[VALUE_W-1:BYTE_W];
          end
          IDX_MATCH_STATUS: begin
            state_d.rdata[CHANNELS-1:0] = state_q.matchStatus;
          end
          default: begin
            state_d.rdata = DATA_ZERO;
          end
        endcase
      end
    end

    // any high-byte write only loads the one shared latch
    if (wrByte) begin
      case (index)
        IDX_COUNT_HIGH, IDX_CMP_A_HIGH, IDX_CMP_B_HIGH, IDX_CMP_C_HIGH: begin
          state_d.temp = wrData;
        end
        default: begin
          state_d.temp = state_d.temp;
        end
      endcase
    end

    // block lives until the tick after the write; a new write re-arms it
    if (countWrite) begin
      state_d.blockPending = 1'b1;
    end else if (timerTick) begin
      state_d.blockPending = 1'b0;
    end

    // sticky matches, write one to clear; a match in the clear cycle wins
    if (wrByte && (index == IDX_MATCH_STATUS)) begin
      state_d.matchStatus = state_q.matchStatus & ~wrData[CHANNELS-1:0];
    end
    state_d.matchStatus = state_d.matchStatus | matchPulse;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q.bus <= BUS_IDLE;
      state_q.temp <= BYTE_RESET;
      state_q.rdata <= DATA_ZERO;
      state_q.blockPending <= 1'b0;
      state_q.matchStatus <= CHAN_ZERO;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // ack is a register, so the answer always comes one edge after the request
  assign wbRsp.ack = (state_q.bus == BUS_ACK);
  assign wbRsp.dat = state_q.rdata;
  assign compareMatch = matchPulse;

endmodule : timer4_counter_compare_regs

/* File: timer4_counter_compare_regs_tb.sv */
// Purpose: self-checking bench of the timer register block
// Assumes: tick driven here, bus through the cpu model
// Notes: ticks stay off while software writes
`timescale 1ns/1ps
module timer4_counter_compare_regs_tb
  import timer4_pkg::*;
;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic timerTick = 1'b0;
  wb_req_t wbReq;
  wb_rsp_t wbRsp;
  logic [CHANNELS-1:0] compareMatch;
  logic [VALUE_W-1:0] liveCount;
  int miscompares = 0;
  int testsRun = 0;
  logic [VALUE_W-1:0] d;
  // 250 MHz clock
  initial forever #2 clock = ~clock;
  cpu_bus_model cpu (.clock(clock), .wbReq(wbReq), .wbRsp(wbRsp));
  timer4_counter_compare_regs dut (.clock(clock), .srst(srst), .wbReq(wbReq),
    .wbRsp(wbRsp), .timerTick(timerTick), .compareMatch(compareMatch),
    .liveCount(liveCount));
  // ********
  // helpers
  // ********
  task automatic finish_test();
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [VALUE_W-1:0] e, input logic [VALUE_W-1:0] g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  // a missing ack ends the run
  task automatic busOk(input logic ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value ack: expected 1 seen 0");
      finish_test();
    end
  endtask : busOk
  task automatic rd(input logic [IDX_W-1:0] ix, output logic [VALUE_W-1:0] v);
    logic [BYTE_W-1:0] b;
    logic ok;
    cpu.access(1'b0, ix, BYTE_RESET, b, ok);
    busOk(ok);
    v = {8'h00, b};
  endtask : rd
  task automatic wr(input logic [IDX_W-1:0] ix, input logic [BYTE_W-1:0] v);
    logic [BYTE_W-1:0] b;
    logic ok;
    cpu.access(1'b1, ix, v, b, ok);
    busOk(ok);
  endtask : wr
  task automatic wr16(input logic [IDX_W-1:0] ix, input logic [VALUE_W-1:0] v);
    logic ok;
    cpu.write16(ix, v, ok);
    busOk(ok);
  endtask : wr16
  task automatic doReset();
    srst <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
  endtask : doReset
  // ********
  // scenarios
  // ********
  // all locations read zero; 0x10 is unmapped and ignores writes
  task automatic tReset();
    logic [IDX_W-1:0] ix [10] = '{IDX_COUNT_LOW, IDX_COUNT_HIGH, IDX_CMP_A_LOW,
      IDX_CMP_A_HIGH, IDX_CMP_B_LOW, IDX_CMP_B_HIGH, IDX_CMP_C_LOW, IDX_CMP_C_HIGH,
      IDX_MATCH_STATUS, 8'h10};
    wr(8'h10, 8'h5a);
    for (int i = 0; i < 10; i++) begin
      rd(ix[i], d);
      chk("reset byte", 16'h0000, d);
    end
    chk("reset count", VALUE_RESET, liveCount);
    $display("test reset done");
  endtask : tReset
  // pairing through the one shared latch
  task automatic tCount();
    wr16(IDX_COUNT_LOW, 16'h1234);
    chk("count", 16'h1234, liveCount);
    rd(IDX_COUNT_LOW, d);
    chk("count low", 16'h0034, d);
    rd(IDX_COUNT_HIGH, d);
    chk("count high", 16'h0012, d);
    wr(IDX_CMP_A_HIGH, 8'h56);
    rd(IDX_CMP_A_HIGH, d);
    chk("cmp a high", 16'h0000, d);
    rd(IDX_COUNT_HIGH, d);
    chk("latch", 16'h0056, d);
    wr(IDX_COUNT_HIGH, 8'h77);
    chk("count kept", 16'h1234, liveCount);
    $display("test count done");
  endtask : tCount
  // the pulse is seen one tick after equality, so the count reads value plus 1
  task automatic tCompare();
    logic [VALUE_W-1:0] seen [CHANNELS] = '{default: 16'h0000};
    wr16(IDX_CMP_A_LOW, 16'h0110);
    wr16(IDX_CMP_B_LOW, 16'h01a0);
    wr16(IDX_CMP_C_LOW, 16'h0130);
    rd(IDX_CMP_B_LOW, d);
    chk("cmp b low", 16'h0020, d);
    wr16(IDX_COUNT_LOW, 16'h010e);
    timerTick <= 1'b1;
    repeat (48) begin
      @(posedge clock);
      for (int c = 0; c < CHANNELS; c++) begin
        if (compareMatch[c] === 1'b1) seen[c] = liveCount;
      end
    end
    timerTick <= 1'b0;
    chk("match a", 16'h0111, seen[CH_A]);
    chk("match b", 16'h0121, seen[CH_B]);
    chk("match c", 16'h0131, seen[CH_C]);
    rd(IDX_MATCH_STATUS, d);
    chk("status", 16'h0007, d);
    wr(IDX_MATCH_STATUS, 8'h07);
    rd(IDX_MATCH_STATUS, d);
    chk("status clear", 16'h0000, d);
    $display("test compare done");
  endtask : tCompare
  // first tick after a count write never matches, the second may
  task automatic tBlock();
    int hits;
    wr16(IDX_COUNT_LOW, 16'h0110);
    for (int k = 0; k < 2; k++) begin
      hits = 0;
      timerTick <= 1'b1;
      repeat (k + 1) @(posedge clock);
      timerTick <= 1'b0;
      repeat (4) begin
        @(posedge clock);
        hits += (compareMatch[CH_A] === 1'b1);
      end
      chk("a hits", 16'(k), 16'(hits));
      if (k == 0) chk("count", 16'h0111, liveCount);
      if (k == 0) wr16(IDX_COUNT_LOW, 16'h010f);
    end
    $display("test block done");
  endtask : tBlock
  // main sequence, with a second reset in mid-run
  initial begin
    doReset();
    tReset();
    tCount();
    tCompare();
    tBlock();
    doReset();
    tReset();
    finish_test();
  end
endmodule : timer4_counter_compare_regs_tb

/* File: timer4_pkg.sv */
// Purpose: shared constants and types of the 16-bit timer register block
// Assumes: classic wishbone slave, 32-bit data, register index = byte address / 4
// Notes: narrow registers sit in data bits 7:0, upper bits read as zero
package timer4_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam int BYTE_W = 8;
  localparam int VALUE_W = 16;
  localparam int CHANNELS = 3;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [IDX_W-1:0] IDX_COUNT_LOW = 8'ha4;
  localparam logic [IDX_W-1:0] IDX_COUNT_HIGH = 8'ha5;
  localparam logic [IDX_W-1:0] IDX_CMP_A_LOW = 8'ha8;
  localparam logic [IDX_W-1:0] IDX_CMP_A_HIGH = 8'ha9;
  localparam logic [IDX_W-1:0] IDX_CMP_B_LOW = 8'haa;
  localparam logic [IDX_W-1:0] IDX_CMP_B_HIGH = 8'hab;
  localparam logic [IDX_W-1:0] IDX_CMP_C_LOW = 8'hac;
  localparam logic [IDX_W-1:0] IDX_CMP_C_HIGH = 8'had;
  localparam logic [IDX_W-1:0] IDX_MATCH_STATUS = 8'hae;

  // ************************************************************
  // reset values and field masks
  // ************************************************************
  localparam logic [VALUE_W-1:0] VALUE_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [CHANNELS-1:0] CHAN_ZERO = 3'h0;
  localparam logic [VALUE_W-1:0] COUNT_STEP = 16'h0001;
  // bit 7 of the b and c low bytes is read-only
  localparam logic [BYTE_W-1:0] LOW_WMASK_A = 8'hff;
  localparam logic [BYTE_W-1:0] LOW_WMASK_BC = 8'h7f;
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam int CH_C = 2;

  // ************************************************************
  // carriers and state
  // ************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [DATA_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] dat;
  } wb_rsp_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  typedef struct packed {
    bus_state_t bus;
    logic [BYTE_W-1:0] temp;
    logic [DATA_W-1:0] rdata;
    logic blockPending;
    logic [CHANNELS-1:0] matchStatus;
  } top_state_t;

endpackage : timer4_pkg

/* File: timer4_regs_sva.sv */
// Purpose: port checks of the timer register block
// Assumes: one clock, srst synchronous active high
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module timer4_regs_sva
  import timer4_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // bus
  input wire wb_req_t wbReq,
  input wire wb_rsp_t wbRsp,
  // timer side
  input wire logic timerTick,
  input wire logic [CHANNELS-1:0] compareMatch,
  input wire logic [VALUE_W-1:0] liveCount
);
  // ********
  // helpers
  // ********
  logic taken;
  logic anyWr;
  logic cntWr;
  // taken only while idle; a held request over ack is not new
  assign taken = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  assign anyWr = wbReq.cyc && wbReq.stb && wbReq.we;
  assign cntWr = taken && wbReq.we && wbReq.sel[0] && wbReq.adr[9:2] == IDX_COUNT_LOW;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // count write, then a quiet cycle, then the first tick
  sequence s_wrGap;
    cntWr && !timerTick ##1 !timerTick ##1 timerTick;
  endsequence
  property p_ack_one; taken |=> wbRsp.ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("no ack after request");
  property p_ack_pulse; wbRsp.ack |=> !wbRsp.ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_rd_byte; wbRsp.ack |-> wbRsp.dat[31:8] == 24'h000000; endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("upper data not zero");
  property p_load; cntWr |=> liveCount[7:0] == $past(wbReq.dat[7:0]); endproperty
  a_load: assert property (p_load) else $error("count low not loaded");
  property p_step; timerTick && !anyWr |=> liveCount == $past(liveCount) + COUNT_STEP;
  endproperty
  a_step: assert property (p_step) else $error("count did not step");
  property p_hold; !timerTick && !anyWr |=> $stable(liveCount); endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_block; s_wrGap |-> ##1 compareMatch == CHAN_ZERO; endproperty
  a_block: assert property (p_block) else $error("match not blocked");
  property p_cause; compareMatch != CHAN_ZERO |-> $past(timerTick); endproperty
  a_cause: assert property (p_cause) else $error("match without tick");
  property p_pulse; compareMatch[CH_A] |=> !compareMatch[CH_A]; endproperty
  a_pulse: assert property (p_pulse) else $error("match too long");
endmodule : timer4_regs_sva

bind timer4_counter_compare_regs timer4_regs_sva chk (.clock(clock), .srst(srst),
  .wbReq(wbReq), .wbRsp(wbRsp), .timerTick(timerTick), .compareMatch(compareMatch),
  .liveCount(liveCount));
